/* dv/rioc_front_model.sv */
// Purpose: behavioural front end feeding residual samples and RMS values
// Assumes: one sample every four clocks, square wave of height amp
// Notes: between strobes the sample lines are scrambled, not held
`timescale 1ns/1ns
module rioc_front_model (
	input wire logic clk, // Processing clock
	input wire logic rst_n, // Reset, active low
	input wire logic [15:0] amp, // Wave amplitude
	input wire logic [15:0] rms_set, // RMS value to report
	output logic sample_valid, // Sample strobe
	output logic signed [15:0] residual_sample, // Sample value
	output logic [15:0] fundamental_rms // RMS value
);
	logic [1:0] phase_r;
	logic sign_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= 2'h0;
			sign_r <= 1'b0;
			sample_valid <= 1'b0;
			residual_sample <= 16'h0000;
			fundamental_rms <= 16'h0000;
		end else begin
			phase_r <= phase_r + 2'h1;
			sample_valid <= (phase_r == 2'h3);
			if (phase_r == 2'h3) begin
				sign_r <= ~sign_r;
				residual_sample <= sign_r ? -amp : amp;
			end else begin
				// Stale value must not be mistaken for a sample
				residual_sample <= ~residual_sample;
			end
			fundamental_rms <= rms_set;
		end
	end
endmodule

/* dv/rioc_unit_test.sv */
// Purpose: self-checking bench of the residual overcurrent unit
// Assumes: short peak window of 64 cycles
// Notes: trip latency is at most a sample period plus two cycles
`timescale 1ns/1ns
`include "rioc_map.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED at %0t got %h exp %h", $time, g, e); end end
module rioc_unit_test;
	import rioc_pkg::*;
	logic hclk = 1'b0;
	logic hresetn, hsel, hwrite, dbl, blk, hreadyout, hresp, sv, gtrip, irq;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, rd;
	logic signed [15:0] smp;
	logic [15:0] rms, amp, rms_set;
	int bad_count, checks;
	always #25 hclk = ~hclk;
	rioc_front_model i_fe (.clk(hclk), .rst_n(hresetn), .amp(amp), .rms_set(rms_set),
		.sample_valid(sv), .residual_sample(smp), .fundamental_rms(rms));
	rioc_unit #(.PEAK_WIN_CYC(64)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.sample_valid(sv), .residual_sample(smp), .fundamental_rms(rms),
		.threshold_doubler(dbl), .block_request(blk), .general_trip_out(gtrip), .irq(irq));
	// ***
	// Bus and check tasks
	// ***
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(rd, e)
		`CHK(hresp, 1'b0)
	endtask
	task automatic trip(input logic e);
		repeat (12) @(posedge hclk);
		`CHK(gtrip, e)
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge hclk);
		bad_count++;
		final_report;
	end
	// ***
	// Tests
	// ***
	initial begin
		{hresetn, hsel, hwrite, dbl, blk} = 5'h00;
		{haddr, htrans, hwdata, amp, rms_set} = '0;
		hsize = 3'h2;
		bad_count = 0;
		checks = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdchk(`RIOC_CTRL_OFS, 32'h0);
		rdchk(`RIOC_START_OFS, 32'hC8);
		rdchk(12'h040, 32'h0);
		rms_set <= 16'h0BB8;
		trip(1'b0);
		bus(1'b1, `RIOC_START_OFS, 32'h5);
		rdchk(`RIOC_START_OFS, 32'h14);
		bus(1'b1, `RIOC_START_OFS, 32'hFA0);
		rdchk(`RIOC_START_OFS, 32'hBB8);
		bus(1'b1, `RIOC_START_OFS, 32'h64);
		$display("settings test done");
		bus(1'b1, `RIOC_IRQ_MASK_OFS, 32'h1);
		rms_set <= 16'h64;
		bus(1'b1, `RIOC_CTRL_OFS, {30'h0, RIOC_OP_FUND});
		trip(1'b0);
		rms_set <= 16'h65;
		trip(1'b1);
		`CHK(irq, 1'b1)
		dbl <= 1'b1;
		trip(1'b0);
		rms_set <= 16'hC8;
		trip(1'b0);
		rms_set <= 16'hC9;
		trip(1'b1);
		blk <= 1'b1;
		trip(1'b0);
		rdchk(`RIOC_STATUS_OFS, 32'hD);
		rdchk(`RIOC_RMS_OFS, 32'hC9);
		blk <= 1'b0;
		trip(1'b1);
		bus(1'b1, `RIOC_IRQ_STAT_OFS, 32'h3);
		rms_set <= 16'h0;
		trip(1'b0);
		rdchk(`RIOC_IRQ_STAT_OFS, 32'h2);
		`CHK(irq, 1'b0)
		$display("fundamental test done");
		bus(1'b1, `RIOC_CTRL_OFS, 32'h3);
		rdchk(`RIOC_CTRL_OFS, 32'h0);
		rms_set <= 16'h0BB8;
		trip(1'b0);
		dbl <= 1'b0;
		rms_set <= 16'h0;
		amp <= 16'h64;
		bus(1'b1, `RIOC_CTRL_OFS, {30'h0, RIOC_OP_PEAK});
		trip(1'b0);
		amp <= 16'h96;
		trip(1'b1);
		rdchk(`RIOC_PEAK_OFS, 32'h96);
		bus(1'b1, `RIOC_CTRL_OFS, {30'h0, RIOC_OP_FUND});
		trip(1'b0);
		$display("peak test done");
		final_report;
	end
endmodule

/* hdl/rioc_unit.sv */
// Purpose: residual overcurrent unit, instantaneous trip decision with AHB-Lite registers
// Assumes: samples and RMS values are percent of nominal, synchronous to hclk
// Notes: all outputs registered
`timescale 1ns/1ns
`include "rioc_map.svh"

module rioc_unit
	import rioc_pkg::*;
#(
	parameter int PEAK_WIN_CYC = `RIOC_PEAK_WIN_CYC
) (
	input wire logic hclk, // Bus and decision clock
	input wire logic hresetn, // Asynchronous reset, active low
	input wire logic hsel, // Slave select
	input wire logic [11:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write when high
	input wire logic [2:0] hsize, // Transfer size
	input wire logic hready, // Bus ready in
	input wire logic [31:0] hwdata, // Write data
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Always OKAY
	input wire logic sample_valid, // New residual sample strobe
	input wire logic signed [15:0] residual_sample, // Sample, percent of nominal
	input wire logic [15:0] fundamental_rms, // Fundamental RMS, percent of nominal
	input wire logic threshold_doubler, // Doubles start threshold
	input wire logic block_request, // Suppresses the general trip
	output logic general_trip_out, // General trip command
	output logic irq // Level interrupt
);

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [15:0] abs16(input logic signed [15:0] v);
		logic [16:0] w;
		w = v[15] ? 17'(-$signed({v[15], v})) : {1'b0, v};
		abs16 = (w > 17'h0FFFF) ? 16'hFFFF : w[15:0];
	endfunction

	function automatic logic [11:0] clamp_start(input logic [31:0] v);
		if (v < 32'(`RIOC_START_MIN)) begin
			clamp_start = `RIOC_START_MIN;
		end else if (v > 32'(`RIOC_START_MAX)) begin
			clamp_start = `RIOC_START_MAX;
		end else begin
			clamp_start = v[11:0];
		end
	endfunction

	// ****************************************
	// Bus slave
	// ****************************************
	rioc_bus_t bus_r;
	logic wr_r;
	logic [11:0] addr_r;
	logic acc;

	rioc_op_t op_r;
	logic [11:0] start_r;
	logic [1:0] irq_stat_r;
	logic [1:0] irq_mask_r;
	logic [15:0] peak_r;
	logic raw_trip;
	logic trip_prev_r;

	assign acc = hsel && hready && htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_r <= RIOC_BUS_IDLE;
			wr_r <= 1'b0;
			addr_r <= 12'h000;
		end else begin
			case (bus_r)
				RIOC_BUS_IDLE: begin
					if (acc) begin
						bus_r <= RIOC_BUS_DATA;
						wr_r <= hwrite;
						addr_r <= haddr;
					end
				end
				RIOC_BUS_DATA: begin
					// Writes take zero wait states: a new address phase may overlap this data phase
					bus_r <= acc ? RIOC_BUS_DATA : RIOC_BUS_IDLE;
					wr_r <= acc ? hwrite : 1'b0;
					addr_r <= acc ? haddr : addr_r;
				end
				default: bus_r <= RIOC_BUS_IDLE;
			endcase
		end
	end

	logic wr_now;
	assign wr_now = (bus_r == RIOC_BUS_DATA) && wr_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			op_r <= RIOC_OP_OFF;
			start_r <= `RIOC_START_RST;
		end else if (wr_now) begin
			if (addr_r == `RIOC_CTRL_OFS) begin
				case (hwdata[`RIOC_CTRL_OP_MSB:`RIOC_CTRL_OP_LSB])
					2'h1: op_r <= RIOC_OP_PEAK;
					2'h2: op_r <= RIOC_OP_FUND;
					default: op_r <= RIOC_OP_OFF;
				endcase
			end else if (addr_r == `RIOC_START_OFS) begin
				start_r <= clamp_start(hwdata);
			end
		end
	end

	// Read data is built combinationally then registered so hrdata is a flop
	logic [31:0] rd_nxt;
	always_comb begin
		rd_nxt = 32'h00000000;
		if (addr_r == `RIOC_CTRL_OFS) begin
			rd_nxt = {30'h0, op_r};
		end else if (addr_r == `RIOC_START_OFS) begin
			rd_nxt = {20'h0, start_r};
		end else if (addr_r == `RIOC_STATUS_OFS) begin
			rd_nxt = {28'h0, threshold_doubler, block_request, general_trip_out, raw_trip};
		end else if (addr_r == `RIOC_IRQ_STAT_OFS) begin
			rd_nxt = {30'h0, irq_stat_r};
		end else if (addr_r == `RIOC_IRQ_MASK_OFS) begin
			rd_nxt = {30'h0, irq_mask_r};
		end else if (addr_r == `RIOC_PEAK_OFS) begin
			rd_nxt = {16'h0, peak_r};
		end else if (addr_r == `RIOC_RMS_OFS) begin
			rd_nxt = {16'h0, fundamental_rms};
		end
	end

	// hrdata is valid one cycle late: a read takes one wait state
	logic rd_pend_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_pend_r <= 1'b0;
			hreadyout <= 1'b1;
			hrdata <= 32'h00000000;
		end else begin
			hrdata <= rd_nxt;
			if (acc && !hwrite && hreadyout) begin
				rd_pend_r <= 1'b1;
				hreadyout <= 1'b0;
			end else begin
				rd_pend_r <= 1'b0;
				hreadyout <= 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// ****************************************
	// Peak selection
	// ****************************************
	// Peak holds the largest magnitude seen in the window, then restarts from
	// the next sample so a cleared fault releases within at most two windows.
	logic [31:0] win_cnt_r;
	logic [15:0] win_max_r;
	logic [15:0] mag;
	assign mag = abs16(residual_sample);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			win_cnt_r <= 32'h00000000;
			win_max_r <= 16'h0000;
			peak_r <= 16'h0000;
		end else if (sample_valid) begin
			if (win_cnt_r >= 32'(PEAK_WIN_CYC - 1)) begin
				win_cnt_r <= 32'h00000000;
				win_max_r <= mag;
				peak_r <= mag;
			end else begin
				win_cnt_r <= win_cnt_r + 32'h00000001;
				win_max_r <= (mag > win_max_r) ? mag : win_max_r;
				// Rising magnitude shows immediately for sub-cycle response
				peak_r <= (mag > peak_r) ? mag : peak_r;
			end
		end else if (win_cnt_r < 32'(PEAK_WIN_CYC - 1)) begin
			win_cnt_r <= win_cnt_r + 32'h00000001;
		end else begin
			win_cnt_r <= 32'h00000000;
			peak_r <= win_max_r;
			win_max_r <= 16'h0000;
		end
	end

	// ****************************************
	// Instantaneous decision and decision logic
	// ****************************************
	logic [15:0] quantity;
	logic [12:0] eff_thr;
	assign quantity = (op_r == RIOC_OP_PEAK) ? peak_r : fundamental_rms;
	assign eff_thr = threshold_doubler ? {start_r, 1'b0} : {1'b0, start_r};
	// No timer between the comparison and the trip flop
	assign raw_trip = (op_r != RIOC_OP_OFF) && (quantity > {3'h0, eff_thr});

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			general_trip_out <= 1'b0;
		end else begin
			// Recomputed every cycle, so it never latches
			general_trip_out <= raw_trip && !block_request
				&& (op_r != RIOC_OP_OFF);
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	logic [1:0] ev;
	assign ev = {trip_prev_r & ~general_trip_out, ~trip_prev_r & general_trip_out};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trip_prev_r <= 1'b0;
			irq_stat_r <= 2'h0;
			irq_mask_r <= 2'h0;
			irq <= 1'b0;
		end else begin
			trip_prev_r <= general_trip_out;
			// Set wins over a write-one clear in the same cycle
			if (wr_now && addr_r == `RIOC_IRQ_STAT_OFS) begin
				irq_stat_r <= (irq_stat_r & ~hwdata[1:0]) | ev;
			end else begin
				irq_stat_r <= irq_stat_r | ev;
			end
			if (wr_now && addr_r == `RIOC_IRQ_MASK_OFS) begin
				irq_mask_r <= hwdata[1:0];
			end
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	a_off_no_trip: assert property (@(posedge hclk) disable iff (!hresetn)
		(op_r == RIOC_OP_OFF) |=> !general_trip_out)
		else $error("trip while operation off");

	a_start_range: assert property (@(posedge hclk) disable iff (!hresetn)
		start_r >= `RIOC_START_MIN && start_r <= `RIOC_START_MAX)
		else $error("start threshold out of range");

	a_double_thr: assert property (@(posedge hclk) disable iff (!hresetn)
		threshold_doubler && op_r == RIOC_OP_FUND && fundamental_rms == {3'h0, start_r, 1'b0}
		|-> !raw_trip)
		else $error("doubled threshold not applied");

	a_block_trip: assert property (@(posedge hclk) disable iff (!hresetn)
		block_request |=> !general_trip_out)
		else $error("trip while blocked");

	a_trip_fast: assert property (@(posedge hclk) disable iff (!hresetn)
		raw_trip && !block_request |=> general_trip_out)
		else $error("trip delayed");

	a_strict_cmp: assert property (@(posedge hclk) disable iff (!hresetn)
		quantity == {3'h0, eff_thr} |-> !raw_trip)
		else $error("equality tripped");

	a_peak_tracks: assert property (@(posedge hclk) disable iff (!hresetn)
		sample_valid && mag > peak_r |=> peak_r == $past(mag))
		else $error("peak missed a rising sample");

	a_select_qty: assert property (@(posedge hclk) disable iff (!hresetn)
		op_r == RIOC_OP_FUND && fundamental_rms > {3'h0, eff_thr} |-> raw_trip)
		else $error("fundamental not compared");

	a_non_latch: assert property (@(posedge hclk) disable iff (!hresetn)
		(quantity <= {3'h0, eff_thr}) || block_request |=> !general_trip_out)
		else $error("trip held without cause");

	a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
		|(irq_stat_r & irq_mask_r) |=> irq)
		else $error("interrupt not raised");

endmodule

/* include/rioc_map.svh */
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 32-bit AHB-Lite word registers, 20 MHz hclk
// Notes: definitions only
`ifndef RIOC_MAP_SVH
`define RIOC_MAP_SVH

`define RIOC_CTRL_OFS 12'h000
`define RIOC_START_OFS 12'h004
`define RIOC_STATUS_OFS 12'h008
`define RIOC_IRQ_STAT_OFS 12'h00C
`define RIOC_IRQ_MASK_OFS 12'h010
`define RIOC_PEAK_OFS 12'h014
`define RIOC_RMS_OFS 12'h018

`define RIOC_CTRL_OP_LSB 0
`define RIOC_CTRL_OP_MSB 1
`define RIOC_START_MIN 12'd20
`define RIOC_START_MAX 12'd3000
`define RIOC_START_RST 12'd200

`define RIOC_ST_RAW 0
`define RIOC_ST_TRIP 1
`define RIOC_ST_BLK 2
`define RIOC_ST_DBL 3

`define RIOC_EV_TRIP_ON 0
`define RIOC_EV_TRIP_OFF 1

// Peak hold decay window: one and a quarter 50 Hz periods
`define RIOC_PEAK_WIN_US 25000
`define RIOC_CLK_MHZ 20
`define RIOC_PEAK_WIN_CYC (`RIOC_PEAK_WIN_US * `RIOC_CLK_MHZ)

`endif

/* include/rioc_pkg.sv */
// Purpose: types shared by the residual overcurrent unit
// Assumes: nothing
// Notes: constants live in rioc_map.svh
package rioc_pkg;
	typedef enum logic [1:0] {
		RIOC_OP_OFF = 2'h0,
		RIOC_OP_PEAK = 2'h1,
		RIOC_OP_FUND = 2'h2
	} rioc_op_t;

	typedef enum logic [1:0] {
		RIOC_BUS_IDLE = 2'b01,
		RIOC_BUS_DATA = 2'b10
	} rioc_bus_t;
endpackage
